/* File: tb/coc_host_model.sv */
`timescale 1ns/1ns
module coc_host_model (
	input  wire logic             clk,
	output coc_pkg::coc_reg_req_t regReq,
	input  wire logic [7:0]       regRdata,
	input  wire logic             regRdValid
);
	import coc_pkg::*;
	initial regReq = '0;
	// Whole-byte write strobe, reserved bit left to caller
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) regReq <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
		@(posedge clk) regReq <= '0;
	endtask : wr
	task rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(posedge clk) regReq <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk) regReq <= '0;
		#1;
		d = regRdata;
		v = regRdValid;
	endtask : rd
endmodule : coc_host_model

/* File: tb/testbench.sv */
`timescale 1ns/1ns
module testbench;
	import coc_pkg::*;
	logic          clk = 0, rst_n = 0, cmpAbove = 0, batBelow = 0, cgIn = 1;
	coc_reg_req_t  req;
	logic [7:0]    rdata;
	logic          rdv, comparator_output, refSel, inSw, outSw, cgFlag, shipOn, wakeOn;
	int            bad_count = 0, checks_done = 0;
	always #4 clk = ~clk;
	coc_option_ctl #(.DEG_2MS_CYC(30'd20), .DEG_5S_CYC(30'd40), .SHIP_CYC(25'd30), .WAKE_CYC(38'd50)) dut (
		.clk(clk), .rst_n(rst_n), .clkEn(1'b1), .regReq(req), .regRdata(rdata), .regRdValid(rdv),
		.comparatorInputAbove(cmpAbove), .batteryBelowMin(batBelow), .chargeGoodIn(cgIn),
		.comparatorOutput(comparator_output), .comparatorReferenceSel(refSel), .inputSideSwitchOn(inSw),
		.outputSideSwitchOn(outSw), .chargeGoodFlag(cgFlag), .shippingDischargeOn(shipOn),
		.wakeupChargeOn(wakeOn));
	coc_host_model host (.clk(clk), .regReq(req), .regRdata(rdata), .regRdValid(rdv));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task bitc(input logic seen, input logic exp);
		chk({7'h00, seen}, {7'h00, exp});
	endtask : bitc
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic       v;
		host.rd(a, d, v);
		bitc(v, 1'b1);
		chk(d, exp);
	endtask : rd_chk
	task stop_test;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task deg_case(input logic [7:0] r, input logic trip, input int n);
		host.wr(8'h30, r);
		@(posedge clk) cmpAbove <= ~trip;
		cyc(6);
		bitc(comparator_output, 1'b1);
		@(posedge clk) cmpAbove <= trip;
		cyc(n);
		bitc(comparator_output, 1'b1);
		cyc(6);
		bitc(comparator_output, r[5:4] == DEG_OFF);
		@(posedge clk) cmpAbove <= ~trip;
		cyc(4);
		bitc(comparator_output, 1'b1);
		$display("deglitch case %h done", r);
	endtask : deg_case
	task wake_case;
		@(posedge clk) batBelow <= 1'b1;
		cyc(5);
		bitc(wakeOn, 1'b1);
		cyc(60);
		bitc(wakeOn, 1'b0);
		rd_chk(8'h30, 8'h10);
		host.wr(8'h30, 8'h11);
		cyc(5);
		bitc(wakeOn, 1'b1);
		@(posedge clk) batBelow <= 1'b0;
		cyc(5);
		bitc(wakeOn, 1'b0);
		rd_chk(8'h30, 8'h10);
		$display("wakeup test done");
	endtask : wake_case
	task ship_case;
		host.wr(8'h30, 8'h12);
		cyc(3);
		bitc(shipOn, 1'b1);
		rd_chk(8'h30, 8'h12);
		cyc(30);
		bitc(shipOn, 1'b0);
		rd_chk(8'h30, 8'h10);
		$display("shipping test done");
	endtask : ship_case
	task cutoff_case;
		@(posedge clk) cmpAbove <= 1'b0;
		host.wr(8'h30, 8'h18);
		cyc(6);
		bitc(inSw & outSw & cgFlag, 1'b1);
		@(posedge clk) cgIn <= 1'b0;
		cyc(2);
		bitc(cgFlag, 1'b0);
		bitc(inSw & outSw, 1'b1);
		@(posedge clk) cgIn <= 1'b1;
		cyc(2);
		bitc(cgFlag, 1'b1);
		@(posedge clk) cmpAbove <= 1'b1;
		cyc(135);
		bitc(inSw, 1'b0);
		bitc(outSw, 1'b0);
		bitc(cgFlag, 1'b0);
		@(posedge clk) cmpAbove <= 1'b0;
		host.wr(8'h30, 8'h10);
		cyc(6);
		bitc(inSw & cgFlag, 1'b1);
		$display("cutoff test done");
	endtask : cutoff_case
	initial begin
		#100000;
		bad_count++;
		stop_test();
	end
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rd_chk(8'h30, CTL_RESET);
		rd_chk(8'h31, 8'h00);
		wake_case();
		ship_case();
		deg_case(8'h10, 1'b1, 125);
		deg_case(8'h20, 1'b1, 20);
		deg_case(8'h30, 1'b1, 40);
		deg_case(8'h00, 1'b1, 125);
		cutoff_case();
		deg_case(8'h50, 1'b0, 125);
		bitc(refSel, 1'b0);
		host.wr(8'h30, 8'h90);
		cyc(3);
		bitc(refSel, 1'b1);
		rd_chk(8'h30, 8'h90);
		$display("reference select test done");
		stop_test();
	end
endmodule : testbench

/* File: verilog/coc_option_ctl.sv */
// Function
// R01: Polarity 0: output low above threshold
// R02: Polarity 1: output low below threshold
// R03: Deglitch delays only the falling output edge
// R04: Deglitch code 00 disables the comparator
// R05: Code 01, default, one microsecond deglitch
// R06: Code 10 gives two millisecond deglitch
// R07: Code 11 gives five second deglitch
// R08: Cutoff enabled and trip opens both switches
// R09: Same event drives charge good low
// R10: Shipping bit set discharges sense node
// R11: Shipping bit self-clears after 140 ms
// R12: Wakeup bit, low battery: charge 30 min
// R13: Battery recovered ends charge, clears bit
// R14: Reference select bit picks comparator reference
// R15: Reads return live self-clearing bit state
// R16: Host writes whole byte, reserved zero
`timescale 1ns/1ns
module coc_option_ctl #(
	parameter logic [coc_pkg::DEG_W-1:0]  DEG_2MS_CYC = coc_pkg::DEG_W'(coc_pkg::DEG_2MS_CYC),
	parameter logic [coc_pkg::DEG_W-1:0]  DEG_5S_CYC  = coc_pkg::DEG_W'(coc_pkg::DEG_5S_CYC),
	parameter logic [coc_pkg::SHIP_W-1:0] SHIP_CYC    = coc_pkg::SHIP_W'(coc_pkg::SHIP_CYC),
	parameter logic [coc_pkg::WAKE_W-1:0] WAKE_CYC    = coc_pkg::WAKE_W'(coc_pkg::WAKE_CYC)
) (
	input  logic                  clk,
	input  logic                  rst_n,
	input  logic                  clkEn,
	input  coc_pkg::coc_reg_req_t regReq,
	output logic [7:0]            regRdata,
	output logic                  regRdValid,
	input  logic                  comparatorInputAbove,
	input  logic                  batteryBelowMin,
	input  logic                  chargeGoodIn,
	output logic                  comparatorOutput,
	output logic                  comparatorReferenceSel,
	output logic                  inputSideSwitchOn,
	output logic                  outputSideSwitchOn,
	output logic                  chargeGoodFlag,
	output logic                  shippingDischargeOn,
	output logic                  wakeupChargeOn
);
	import coc_pkg::*;

	// ----------------------------------------
	// Parameter checks
	// ----------------------------------------
	if (DEG_2MS_CYC < 2 || DEG_5S_CYC < 2 || SHIP_CYC < 1 || WAKE_CYC < 1) begin : g_bad_param
		$error("coc_option_ctl: cycle counts too small");
	end

	coc_state_t              r;
	coc_state_t              n;
	logic                    rawLow;
	logic                    cmpEnabled;
	logic                    trip;
	logic                    hit;
	logic [DEG_W-1:0]        degLimit;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		n = r;
		n.cmpSync = {r.cmpSync[0], comparatorInputAbove};
		n.batSync = {r.batSync[0], batteryBelowMin};
		n.rdValid = 1'b0;
		hit = regReq.addr == CTL_OFFSET;
		rawLow = r.ctl.comparatorPolarity ? !r.cmpSync[1] : r.cmpSync[1]; // R01 R02
		cmpEnabled = r.ctl.comparatorDeglitchSel != DEG_OFF; // R04
		unique case (r.ctl.comparatorDeglitchSel)
			DEG_OFF: degLimit = DEG_W'(DEG_1US_CYC);
			DEG_1US: degLimit = DEG_W'(DEG_1US_CYC); // R05
			DEG_2MS: degLimit = DEG_2MS_CYC; // R06
			DEG_5S:  degLimit = DEG_5S_CYC; // R07
		endcase
		if (!cmpEnabled || !rawLow) begin // R03 R04
			n.degCnt = '0;
			n.comparator_output = 1'b1;
		end else if (r.degCnt >= degLimit - DEG_W'(1)) begin // R03
			n.comparator_output = 1'b0;
		end else begin
			n.degCnt = r.degCnt + DEG_W'(1);
		end
		trip = cmpEnabled && !r.comparator_output;
		if (r.ctl.forcedPathCutoffEn && trip) begin // R08
			n.latched = 1'b1;
		end else if (!r.ctl.forcedPathCutoffEn) begin
			n.latched = 1'b0;
		end
		if (r.ctl.shippingDischargeEn) begin
			if (r.shipCnt >= SHIP_CYC - SHIP_W'(1)) begin // R11
				n.ctl.shippingDischargeEn = 1'b0;
				n.shipCnt = '0;
			end else begin
				n.shipCnt = r.shipCnt + SHIP_W'(1);
			end
		end else begin
			n.shipCnt = '0;
		end
		if (r.ctl.autoWakeupEn && r.batSync[1]) begin // R12
			if (r.wakeCnt >= WAKE_CYC - WAKE_W'(1)) begin
				n.ctl.autoWakeupEn = 1'b0;
				n.wakeOn = 1'b0;
				n.wakeCnt = '0;
			end else begin
				n.wakeOn = 1'b1;
				n.wakeCnt = r.wakeCnt + WAKE_W'(1);
			end
		end else if (r.ctl.autoWakeupEn && r.wakeOn) begin // R13
			n.ctl.autoWakeupEn = 1'b0;
			n.wakeOn = 1'b0;
			n.wakeCnt = '0;
		end else begin
			n.wakeOn = 1'b0;
			n.wakeCnt = '0;
		end
		if (regReq.write && hit) begin // R16
			n.ctl = coc_ctl_t'(regReq.wdata);
			if (!n.ctl.shippingDischargeEn) begin // R10
				n.shipCnt = '0;
			end
			if (!n.ctl.autoWakeupEn) begin // R12
				n.wakeOn = 1'b0;
				n.wakeCnt = '0;
			end
		end
		if (regReq.read) begin
			n.rdValid = 1'b1;
			n.rdata = hit ? 8'(r.ctl) : 8'h00; // R15
		end
		n.switchOn = !n.latched; // R08
		n.chargeGood = chargeGoodIn && !n.latched; // R09
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			r <= STATE_RESET;
		end else if (clkEn) begin
			r <= n;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign regRdata               = r.rdata;
	assign regRdValid             = r.rdValid;
	assign comparatorOutput       = r.comparator_output;
	assign comparatorReferenceSel = r.ctl.comparatorReferenceSel; // R14
	assign inputSideSwitchOn      = r.switchOn;
	assign outputSideSwitchOn     = r.switchOn;
	assign chargeGoodFlag         = r.chargeGood;
	assign shippingDischargeOn    = r.ctl.shippingDischargeEn; // R10
	assign wakeupChargeOn         = r.wakeOn;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk iff clkEn);
	endclocking
	default disable iff (!rst_n);

	sequence tripSeen;
		r.ctl.forcedPathCutoffEn && r.ctl.comparatorDeglitchSel != DEG_OFF && !r.comparator_output;
	endsequence

	sequence wakeRecovered;
		r.ctl.autoWakeupEn && r.wakeOn && !r.batSync[1] && !regReq.write;
	endsequence

	pol_low_a: assert property (!r.comparator_output && !$past(r.ctl.comparatorPolarity) |-> $past(r.cmpSync[1])) // R01
		else $error("output low without input above threshold");
	pol_high_a: assert property (!r.comparator_output && $past(r.ctl.comparatorPolarity) |-> !$past(r.cmpSync[1])) // R02
		else $error("output low without input below threshold");
	rise_fast_a: assert property (r.ctl.comparatorDeglitchSel != DEG_OFF && !rawLow |=> r.comparator_output) // R03
		else $error("rising output edge delayed");
	cmp_off_a: assert property (r.ctl.comparatorDeglitchSel == DEG_OFF |=> r.comparator_output) // R04
		else $error("disabled comparator drove low");
	deg_1us_a: assert property ($fell(r.comparator_output) && $past(r.ctl.comparatorDeglitchSel) == DEG_1US
		|-> $past(r.degCnt) == DEG_W'(DEG_1US_CYC) - DEG_W'(1)) // R05
		else $error("one microsecond deglitch wrong");
	deg_2ms_a: assert property ($fell(r.comparator_output) && $past(r.ctl.comparatorDeglitchSel) == DEG_2MS
		|-> $past(r.degCnt) == DEG_2MS_CYC - DEG_W'(1)) // R06
		else $error("two millisecond deglitch wrong");
	deg_5s_a: assert property ($fell(r.comparator_output) && $past(r.ctl.comparatorDeglitchSel) == DEG_5S
		|-> $past(r.degCnt) == DEG_5S_CYC - DEG_W'(1)) // R07
		else $error("five second deglitch wrong");
	cutoff_switch_a: assert property (tripSeen |=> !inputSideSwitchOn && !outputSideSwitchOn) // R08
		else $error("switches stayed on after trip");
	cutoff_good_a: assert property (tripSeen |=> !chargeGoodFlag) // R09
		else $error("charge good stayed high after trip");
	ship_on_a: assert property (r.shipCnt != '0 |-> shippingDischargeOn) // R10
		else $error("discharge stopped while timing");
	ship_clear_a: assert property (shippingDischargeOn && r.shipCnt == SHIP_CYC - SHIP_W'(1)
		&& !regReq.write |=> !shippingDischargeOn) // R11
		else $error("shipping bit not cleared");
	wake_on_a: assert property (r.ctl.autoWakeupEn && r.batSync[1] && r.wakeCnt < WAKE_CYC - WAKE_W'(1)
		&& !regReq.write |=> wakeupChargeOn) // R12
		else $error("wakeup charge not enabled");
	wake_end_a: assert property (wakeRecovered |=> !wakeupChargeOn && !r.ctl.autoWakeupEn) // R13
		else $error("wakeup charge not ended");
	read_live_a: assert property (regReq.read && hit |=> regRdValid && regRdata == 8'($past(r.ctl))) // R15
		else $error("read data not live");

	// ----------------------------------------
	// Latch, timer and read port guards
	// ----------------------------------------
	switch_off_a: assert property (r.latched |-> !inputSideSwitchOn && !outputSideSwitchOn) // R08
		else $error("switch on while cutoff latched");
	latch_hold_a: assert property (r.latched && r.ctl.forcedPathCutoffEn |=> r.latched) // R08
		else $error("cutoff latch released while enabled");
	cut_release_a: assert property (!r.ctl.forcedPathCutoffEn |=> !r.latched) // R08
		else $error("cutoff latch held while disabled");
	good_follow_a: assert property (!r.latched && !(r.ctl.forcedPathCutoffEn && trip)
		|=> chargeGoodFlag == $past(chargeGoodIn)) // R09
		else $error("charge good not following input");
	ship_bound_a: assert property (shippingDischargeOn |-> r.shipCnt < SHIP_CYC) // R11
		else $error("shipping timer overran");
	read_pulse_a: assert property (!regReq.read |=> !regRdValid) // R15
		else $error("read valid without read");
	unmapped_read_a: assert property (regReq.read && !hit |=> regRdValid && regRdata == 8'h00) // R15
		else $error("unmapped read not zero");
	wake_idle_a: assert property (!r.ctl.autoWakeupEn |=> !wakeupChargeOn) // R12
		else $error("wakeup charge without enable");
	wake_bit_a: assert property (wakeupChargeOn |-> r.ctl.autoWakeupEn) // R13
		else $error("wakeup charge with bit cleared");
	deg_idle_a: assert property (r.ctl.comparatorDeglitchSel == DEG_OFF |=> r.degCnt == '0) // R04
		else $error("deglitch counting while disabled");

endmodule : coc_option_ctl

/* File: verilog/coc_pkg.sv */
package coc_pkg;

	// ----------------------------------------
	// Register map and field layout
	// ----------------------------------------
	localparam logic [7:0] CTL_OFFSET    = 8'h30;
	localparam logic [7:0] CTL_RESET     = 8'h11;
	localparam logic [1:0] DEG_OFF       = 2'h0;
	localparam logic [1:0] DEG_1US       = 2'h1;
	localparam logic [1:0] DEG_2MS       = 2'h2;
	localparam logic [1:0] DEG_5S        = 2'h3;

	typedef struct packed {
		logic       comparatorReferenceSel;
		logic       comparatorPolarity;
		logic [1:0] comparatorDeglitchSel;
		logic       forcedPathCutoffEn;
		logic       reservedBit;
		logic       shippingDischargeEn;
		logic       autoWakeupEn;
	} coc_ctl_t;

	// ----------------------------------------
	// Timing, clock 125 MHz
	// ----------------------------------------
	localparam longint CLK_PERIOD_NS = 8;
	localparam longint DEG_1US_NS    = 1000;
	localparam longint DEG_2MS_NS    = 2000000;
	localparam longint DEG_5S_NS     = 64'd5000000000;
	localparam longint SHIP_140MS_NS = 140000000;
	localparam longint WAKE_30MIN_NS = 30 * 60 * 64'd1000000000;
	localparam longint DEG_1US_CYC   = (DEG_1US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam longint DEG_2MS_CYC   = (DEG_2MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam longint DEG_5S_CYC    = (DEG_5S_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam longint SHIP_CYC      = SHIP_140MS_NS / CLK_PERIOD_NS;
	localparam longint WAKE_CYC      = WAKE_30MIN_NS / CLK_PERIOD_NS;
	localparam int     DEG_W         = 30;
	localparam int     SHIP_W        = 25;
	localparam int     WAKE_W        = 38;

	// ----------------------------------------
	// Carriers and state
	// ----------------------------------------
	typedef struct packed {
		logic       write;
		logic       read;
		logic [7:0] addr;
		logic [7:0] wdata;
	} coc_reg_req_t;

	typedef struct packed {
		coc_ctl_t            ctl;
		logic [1:0]          cmpSync;
		logic [1:0]          batSync;
		logic [DEG_W-1:0]    degCnt;
		logic                comparator_output;
		logic                latched;
		logic [SHIP_W-1:0]   shipCnt;
		logic [WAKE_W-1:0]   wakeCnt;
		logic                wakeOn;
		logic                switchOn;
		logic                chargeGood;
		logic [7:0]          rdata;
		logic                rdValid;
	} coc_state_t;

	localparam coc_state_t STATE_RESET = '{
		ctl: CTL_RESET, cmpSync: 2'h0, batSync: 2'h0, degCnt: '0, comparator_output: 1'b1,
		latched: 1'b0, shipCnt: '0, wakeCnt: '0, wakeOn: 1'b0, switchOn: 1'b1,
		chargeGood: 1'b0, rdata: 8'h00, rdValid: 1'b0};

endpackage : coc_pkg
